// ### hdl/ddr_front.sv
// DDR controller front end: chip-select decode, row/bank/column split
// and the automatic power-up command sequence.
// Assumes a register master on sys_clk_i and a free memory clock input
// that is slower than sys_clk_i; command pins change on the third sys_clk_i edge after its rising edge.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Column goes out on pin 11 then pins 9..0; pin 10 never carries column.
// - 14x11 wide mode: row from bits 28-15, bank 14-13, column 12-2.
// - Separate row, bank, column placement per geometry, narrow and wide.
// - Row width per chip select may be 12, 13 or 14 bits.
// - Column width per chip select may be 8, 9, 10 or 11 bits.
// - Row code 000 means 12 rows; column code 001 means 9 columns.
// - Enable raises clock enable and starts the init sequence by itself.
// - NOP, precharge all, extended mode set with DLL on, wait two cycles.
// - Mode set with DLL reset, wait two, precharge all, wait precharge time.
// - Two auto refreshes, each followed by the refresh period.
// - Final mode set without DLL reset, then wait two cycles.
// - Steps from NOP through last wait run with no software help.
// - Two chip selects with start and end bounds; inside range selects.
// - Bounds compare with top 10 address bits narrow, top 9 wide.
// - A chip select decodes only while its enable bit is set.
// - Auto-precharge enable requests auto precharge on every access.
// - Address line 10 high asks auto precharge, low keeps row open.
// - Precharge uses address line 10 to pick all banks or one.
module ddr_front
	import ddr_front_pkg::*;
#(
	parameter logic [4:0] TRP_CK = 5'h02,
	parameter logic [4:0] TRFC_CK = 5'h09,
	parameter logic [13:0] EXT_MODE_VALUE = 14'h0000,
	parameter logic [13:0] MODE_VALUE = 14'h0021,
	parameter int DLL_RESET_BIT = 8
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic mem_clk_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [31:0] req_addr_i,
	output logic req_ready_o,
	output logic dec_valid_o,
	output dec_s dec_o,
	output cmd_s mem_cmd_o,
	output logic mem_cke_o
);
	typedef enum logic [10:0] {
		ST_IDLE = 11'b000_0000_0001,
		ST_NOP = 11'b000_0000_0010,
		ST_PREA1 = 11'b000_0000_0100,
		ST_EMRS = 11'b000_0000_1000,
		ST_MRS_DLL = 11'b000_0001_0000,
		ST_PREA2 = 11'b000_0010_0000,
		ST_AREF1 = 11'b000_0100_0000,
		ST_AREF2 = 11'b000_1000_0000,
		ST_MRS_RUN = 11'b001_0000_0000,
		ST_FINAL = 11'b010_0000_0000,
		ST_READY = 11'b100_0000_0000
	} init_e;

	logic [31:0] bounds_ff [2];
	logic [31:0] geom_ff [2];
	logic [31:0] ctrl_ff;
	logic [31:0] rdata_ff;
	logic [2:0] mclk_ff;
	init_e state_ff, nxt_state;
	cmd_s cmd_ff, nxt_cmd;
	logic [4:0] wait_ff, nxt_wait;
	logic nxt_issue;
	logic cke_ff;
	logic dec_valid_ff;
	dec_s dec_ff;

	// Register port
	wire interface_enable_bit = ctrl_ff[CTRL_EN_BIT];
	wire wide = ctrl_ff[CTRL_WIDE_BIT];
	wire init_done = (state_ff == ST_READY);
	wire [31:0] status = {init_done, 20'h0_0000, state_ff};
	wire [31:0] rd_mux =
		(reg_addr_i == REG_CS0_BOUNDS) ? bounds_ff[0] :
		(reg_addr_i == REG_CS1_BOUNDS) ? bounds_ff[1] :
		(reg_addr_i == REG_CS0_GEOM) ? geom_ff[0] :
		(reg_addr_i == REG_CS1_GEOM) ? geom_ff[1] :
		(reg_addr_i == REG_CTRL) ? ctrl_ff :
		(reg_addr_i == REG_STATUS) ? status : 32'h0000_0000;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_ff <= REG_RESET;
			rdata_ff <= REG_RESET;
		end else begin
			if (reg_wr_i && reg_addr_i == REG_CTRL)
				ctrl_ff <= reg_wdata_i;
			rdata_ff <= reg_rd_i ? rd_mux : 32'h0000_0000;
		end
	end
	assign reg_rdata_o = rdata_ff;

	// Per chip select: bounds match and geometry
	logic [1:0] cs_in;
	logic [4:0] cs_cols [2];
	logic [4:0] cs_rows [2];
	logic [1:0] cs_ap;
	wire [9:0] top_bits = wide ? {1'b0, req_addr_i[31:23]} :
		req_addr_i[31:22];
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cs
			wire [7:0] b_addr = (gi == 0) ? REG_CS0_BOUNDS :
				REG_CS1_BOUNDS;
			wire [7:0] g_addr = (gi == 0) ? REG_CS0_GEOM : REG_CS1_GEOM;
			wire [9:0] st_raw = bounds_ff[gi][BND_START_LSB +: BND_W];
			wire [9:0] en_raw = bounds_ff[gi][BND_END_LSB +: BND_W];
			wire [9:0] st_f = wide ? {1'b0, st_raw[8:0]} : st_raw;
			wire [9:0] en_f = wide ? {1'b0, en_raw[8:0]} : en_raw;
			wire [2:0] rc = geom_ff[gi][GEOM_ROW_LSB +: 3];
			wire [2:0] cc = geom_ff[gi][GEOM_COL_LSB +: 3];
			always_ff @(posedge sys_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					bounds_ff[gi] <= REG_RESET;
					geom_ff[gi] <= REG_RESET;
				end else begin
					if (reg_wr_i && reg_addr_i == b_addr)
						bounds_ff[gi] <= reg_wdata_i;
					if (reg_wr_i && reg_addr_i == g_addr)
						geom_ff[gi] <= reg_wdata_i;
				end
			end
			assign cs_in[gi] = geom_ff[gi][GEOM_EN_BIT] &&
				top_bits >= st_f && top_bits <= en_f;
			// Out-of-range codes clamp to the widest legal geometry
			assign cs_rows[gi] = ROW_BASE +
				((rc > ROW_CODE_MAX) ? {2'b00, ROW_CODE_MAX} : {2'b00, rc});
			assign cs_cols[gi] = COL_BASE +
				((cc > COL_CODE_MAX) ? {2'b00, COL_CODE_MAX} : {2'b00, cc});
			assign cs_ap[gi] = geom_ff[gi][GEOM_AP_BIT];
		end
	endgenerate

	// Address split; select 0 wins if both ranges overlap
	wire sel = !cs_in[0];
	wire [4:0] ncol = cs_cols[sel];
	wire [4:0] nrow = cs_rows[sel];
	wire [4:0] offs = wide ? OFFS_WIDE : OFFS_NARROW;
	wire [4:0] bsh = offs + ncol;
	wire [4:0] rsh = bsh + 5'h02;
	wire [31:0] col_raw = req_addr_i >> offs;
	wire [31:0] bank_raw = req_addr_i >> bsh;
	wire [31:0] row_raw = req_addr_i >> rsh;
	wire [31:0] col_mask = (32'h0000_0001 << ncol) - 32'h0000_0001;
	wire [31:0] row_mask = (32'h0000_0001 << nrow) - 32'h0000_0001;
	wire [10:0] col_bits = col_raw[10:0] & col_mask[10:0];
	wire [13:0] row_bits = row_raw[13:0] & row_mask[13:0];
	wire ap_sel = cs_ap[sel];
	wire [13:0] col_pins = {2'b00, col_bits[10], ap_sel, col_bits[9:0]};
	wire hit = |cs_in;
	wire accept = req_valid_i && req_ready_o;

	assign req_ready_o = init_done;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dec_valid_ff <= 1'b0;
			dec_ff <= '0;
		end else begin
			dec_valid_ff <= accept;
			if (accept)
				dec_ff <= '{hit: hit, write: req_write_i,
					cs: hit ? {sel, !sel} : 2'b00,
					row: row_bits, ba: bank_raw[1:0], col_ma: col_pins};
		end
	end
	assign dec_valid_o = dec_valid_ff;
	assign dec_o = dec_ff;

	// Memory clock: two flops, then edge find on the settled copies
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			mclk_ff <= 3'h0;
		else
			mclk_ff <= {mclk_ff[1:0], mem_clk_i};
	end
	wire mem_edge = mclk_ff[1] && !mclk_ff[2];
	wire fire = (wait_ff == NO_WAIT_CK);

	// Init commands go to every enabled chip select at once
	wire [1:0] en_cs_n = ~{geom_ff[1][GEOM_EN_BIT], geom_ff[0][GEOM_EN_BIT]};
	wire [13:0] pre_all = 14'h0001 << MA_AP_BIT;
	wire [13:0] dll_rst = 14'h0001 << DLL_RESET_BIT;

	always_comb begin
		nxt_state = state_ff;
		nxt_wait = fire ? NO_WAIT_CK : wait_ff - 5'h01;
		nxt_issue = 1'b0;
		nxt_cmd = '{cs_n: en_cs_n, rcw_n: CMD_NOP, ba: BA_MODE,
			ma: 14'h0000};
		case (state_ff)
			ST_IDLE: begin
				nxt_cmd = CMD_IDLE;
				nxt_state = ST_NOP;
			end
			ST_NOP: if (fire) begin
				nxt_issue = 1'b1;
				nxt_state = ST_PREA1;
			end
			ST_PREA1: if (fire) begin
				nxt_issue = 1'b1;
				nxt_cmd.rcw_n = CMD_PRE;
				nxt_cmd.ma = pre_all;
				nxt_state = ST_EMRS;
			end
			ST_EMRS: if (fire) begin
				nxt_issue = 1'b1;
				nxt_cmd.rcw_n = CMD_MRS;
				nxt_cmd.ba = BA_EXT_MODE;
				nxt_cmd.ma = EXT_MODE_VALUE;
				nxt_wait = MRS_WAIT_CK;
				nxt_state = ST_MRS_DLL;
			end
			ST_MRS_DLL: if (fire) begin
				nxt_issue = 1'b1;
				nxt_cmd.rcw_n = CMD_MRS;
				nxt_cmd.ma = MODE_VALUE | dll_rst;
				nxt_wait = MRS_WAIT_CK;
				nxt_state = ST_PREA2;
			end
			ST_PREA2: if (fire) begin
				nxt_issue = 1'b1;
				nxt_cmd.rcw_n = CMD_PRE;
				nxt_cmd.ma = pre_all;
				nxt_wait = TRP_CK;
				nxt_state = ST_AREF1;
			end
			ST_AREF1: if (fire) begin
				nxt_issue = 1'b1;
				nxt_cmd.rcw_n = CMD_REF;
				nxt_wait = TRFC_CK;
				nxt_state = ST_AREF2;
			end
			ST_AREF2: if (fire) begin
				nxt_issue = 1'b1;
				nxt_cmd.rcw_n = CMD_REF;
				nxt_wait = TRFC_CK;
				nxt_state = ST_MRS_RUN;
			end
			ST_MRS_RUN: if (fire) begin
				nxt_issue = 1'b1;
				nxt_cmd.rcw_n = CMD_MRS;
				nxt_cmd.ma = MODE_VALUE & ~dll_rst;
				nxt_wait = MRS_WAIT_CK;
				nxt_state = ST_FINAL;
			end
			ST_FINAL: if (fire)
				nxt_state = ST_READY;
			ST_READY: nxt_cmd = CMD_IDLE;
			default: begin
				nxt_cmd = CMD_IDLE;
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Clearing the enable aborts the sequence; memory sees deselect
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= ST_IDLE;
			cmd_ff <= CMD_IDLE;
			wait_ff <= NO_WAIT_CK;
			cke_ff <= 1'b0;
		end else begin
			cke_ff <= interface_enable_bit;
			if (!interface_enable_bit) begin
				state_ff <= ST_IDLE;
				cmd_ff <= CMD_IDLE;
				wait_ff <= NO_WAIT_CK;
			end else if (mem_edge) begin
				state_ff <= nxt_state;
				cmd_ff <= nxt_cmd;
				wait_ff <= nxt_wait;
			end
		end
	end
	assign mem_cmd_o = cmd_ff;
	assign mem_cke_o = cke_ff;

	// Helper: memory edges since the last issued command, saturating
	logic [4:0] gap_ff;
	wire issue_now = interface_enable_bit && mem_edge && nxt_issue;
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			gap_ff <= 5'h00;
		else if (issue_now)
			gap_ff <= 5'h00;
		else if (mem_edge && gap_ff != 5'h1f)
			gap_ff <= gap_ff + 5'h01;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	chk_cke_follows_en: assert property (
		$rose(interface_enable_bit) |=> mem_cke_o ##0 (state_ff == ST_IDLE ||
		state_ff == ST_NOP))
		else $error("clock enable or sequence start missing");
	chk_ready_gate: assert property (
		req_valid_i && !req_ready_o |=> !dec_valid_o)
		else $error("request taken before init done");
	chk_first_is_nop: assert property (
		issue_now && state_ff == ST_NOP |=>
		mem_cmd_o.rcw_n == CMD_NOP && mem_cmd_o.cs_n == en_cs_n)
		else $error("sequence did not open with NOP");
	chk_prea_all_a10: assert property (
		interface_enable_bit && mem_cmd_o.rcw_n == CMD_PRE && mem_cmd_o.cs_n != 2'h3
		|-> mem_cmd_o.ma[MA_AP_BIT])
		else $error("precharge all without line 10 high");
	chk_mrs_gap: assert property (
		issue_now && state_ff == ST_MRS_DLL |-> gap_ff >= 5'h02)
		else $error("mode set issued before two cycle wait");
	chk_refresh_gap: assert property (
		issue_now && (state_ff == ST_AREF2 || state_ff == ST_MRS_RUN)
		|-> gap_ff >= TRFC_CK)
		else $error("refresh period not honoured");
	chk_col_ap_line: assert property (
		accept |=> dec_o.col_ma[MA_AP_BIT] == $past(ap_sel) &&
		dec_o.col_ma[11] == $past(col_bits[10]))
		else $error("column or auto precharge on wrong pin");
	chk_disabled_cs: assert property (
		accept && !geom_ff[0][GEOM_EN_BIT] |=> !dec_o.cs[0])
		else $error("disabled chip select decoded");
	chk_row_12_clear: assert property (
		accept && cs_in[0] && geom_ff[0][GEOM_ROW_LSB +: 3] == 3'h0
		|=> dec_o.row[13:12] == 2'h0 && dec_o.cs == 2'h1)
		else $error("12 row geometry leaked upper row bits");
	chk_wide_14x11: assert property (
		accept && wide && ncol == 5'h0b && nrow == 5'h0e |=>
		dec_o.ba == $past(req_addr_i[14:13]) &&
		dec_o.row == $past(req_addr_i[28:15]))
		else $error("wide 14x11 split wrong");

	cov_init_done: cover property ($rose(init_done));
	cov_hit_cs1: cover property (accept && cs_in == 2'h2);
	cov_miss: cover property (accept && !hit);
	cov_abort: cover property ($fell(interface_enable_bit) && !init_done);
endmodule

// ### common/ddr_front_pkg.sv
// Constants and carriers for the DDR front end: register map, fields,
// geometry codes, command encodings and init-sequence waits.
// Assumes a 32-bit register port with byte addresses, word aligned.
package ddr_front_pkg;
	localparam logic [7:0] REG_CS0_BOUNDS = 8'h00;
	localparam logic [7:0] REG_CS1_BOUNDS = 8'h04;
	localparam logic [7:0] REG_CS0_GEOM = 8'h08;
	localparam logic [7:0] REG_CS1_GEOM = 8'h0c;
	localparam logic [7:0] REG_CTRL = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// Bounds register: start field high, end field low
	localparam int BND_START_LSB = 16;
	localparam int BND_END_LSB = 0;
	localparam int BND_W = 10;
	// Geometry register fields
	localparam int GEOM_EN_BIT = 31;
	localparam int GEOM_AP_BIT = 23;
	localparam int GEOM_ROW_LSB = 8;
	localparam int GEOM_COL_LSB = 0;
	// Control and status register fields
	localparam int CTRL_EN_BIT = 31;
	localparam int CTRL_WIDE_BIT = 0;
	localparam int STS_READY_BIT = 31;
	// Row code 000 = 12 bits upward, column code 000 = 8 bits upward
	localparam logic [4:0] ROW_BASE = 5'h0c;
	localparam logic [4:0] COL_BASE = 5'h08;
	localparam logic [2:0] ROW_CODE_MAX = 3'h2;
	localparam logic [2:0] COL_CODE_MAX = 3'h3;
	localparam logic [4:0] OFFS_NARROW = 5'h01;
	localparam logic [4:0] OFFS_WIDE = 5'h02;
	localparam int MA_AP_BIT = 10;
	// {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [1:0] BA_EXT_MODE = 2'h1;
	localparam logic [1:0] BA_MODE = 2'h0;
	localparam logic [4:0] MRS_WAIT_CK = 5'h02;
	localparam logic [4:0] NO_WAIT_CK = 5'h00;

	typedef struct packed {
		logic [1:0] cs_n;
		logic [2:0] rcw_n;
		logic [1:0] ba;
		logic [13:0] ma;
	} cmd_s;

	typedef struct packed {
		logic hit;
		logic write;
		logic [1:0] cs;
		logic [13:0] row;
		logic [1:0] ba;
		logic [13:0] col_ma;
	} dec_s;

	localparam cmd_s CMD_IDLE = '{cs_n: 2'h3, rcw_n: 3'h7, ba: 2'h0,
		ma: 14'h0000};
endpackage

// ### verif/ddr_mem_model.sv
// Memory-side model: logs every executable command seen at the pins.
// Assumes command pins are settled at each rising memory clock edge.
`timescale 1ns/1ps
module ddr_mem_model
	import ddr_front_pkg::*;
(
	input wire logic mem_clk_i,
	input wire logic cke_i,
	input wire cmd_s cmd_i
);
	cmd_s log_q[$];
	int edge_q[$];
	int edge_cnt = 0;

	// Deselect and NOP do nothing in the array, so they are not logged
	always @(posedge mem_clk_i) begin
		edge_cnt++;
		if (cke_i && cmd_i.cs_n != 2'h3 && cmd_i.rcw_n != CMD_NOP) begin
			log_q.push_back(cmd_i);
			edge_q.push_back(edge_cnt);
		end
	end
endmodule

// ### verif/test_ddr_front.sv
// Testbench for the DDR front end: registers, init sequence, decode.
// Assumes the memory model logs commands at memory clock edges.
`timescale 1ns/1ps
module test_ddr_front;
	import ddr_front_pkg::*;
	// Short waits keep the init sequence brief
	localparam logic [4:0] TRP = 5'h02;
	localparam logic [4:0] TRFC = 5'h03;
	logic sys_clk_i = 1'h0;
	logic resetn_i = 1'h0;
	logic mem_clk_i = 1'h0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_wr_i = 1'h0;
	logic reg_rd_i = 1'h0;
	logic req_valid_i = 1'h0;
	logic req_write_i = 1'h0;
	logic [31:0] req_addr_i = 32'h0000_0000;
	logic [31:0] reg_rdata_o;
	logic req_ready_o;
	logic dec_valid_o;
	logic mem_cke_o;
	dec_s dec_o;
	cmd_s mem_cmd_o;
	int mismatches = 0;
	int check_count = 0;

	ddr_front #(.TRP_CK(TRP), .TRFC_CK(TRFC)) u_ddr_front (.sys_clk_i,
		.resetn_i, .mem_clk_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .req_valid_i, .req_write_i, .req_addr_i,
		.req_ready_o, .dec_valid_o, .dec_o, .mem_cmd_o, .mem_cke_o);
	ddr_mem_model u_ddr_mem_model (.mem_clk_i(mem_clk_i),
		.cke_i(mem_cke_o), .cmd_i(mem_cmd_o));

	initial forever #2.5 sys_clk_i = ~sys_clk_i;
	initial forever #80 mem_clk_i = ~mem_clk_i;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'h0;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'h0;
		#1 chk(nm, e, reg_rdata_o);
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (req_ready_o !== 1'h1 && n < 3000) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (req_ready_o !== 1'h1) begin
			$display("wrong value ready expected 1 seen %b", req_ready_o);
			mismatches++;
			complete_run();
		end
	endtask

	function automatic dec_s exp_dec(logic [31:0] a, int rb, int cb,
		int off, logic ap, logic [1:0] cs, logic w);
		dec_s d;
		logic [31:0] col;
		col = (a >> off) & ((32'h1 << cb) - 1);
		d = '0;
		d.hit = 1'h1;
		d.write = w;
		d.cs = cs;
		d.ba = 2'((a >> (off + cb)) & 3);
		d.row = 14'((a >> (off + cb + 2)) & ((32'h1 << rb) - 1));
		d.col_ma = {2'h0, col[10], ap, col[9:0]};
		return d;
	endfunction

	task automatic dec_chk(input logic [31:0] a, input logic w,
		input dec_s e);
		@(posedge sys_clk_i);
		req_valid_i <= 1'h1;
		req_write_i <= w;
		req_addr_i <= a;
		@(posedge sys_clk_i);
		req_valid_i <= 1'h0;
		#1 chk("dec_valid", 32'h1, 32'(dec_valid_o));
		chk("hit_cs", 32'({e.hit, e.cs}), 32'({dec_o.hit, dec_o.cs}));
		if (e.hit) begin
			chk("row", 32'(e.row), 32'(dec_o.row));
			chk("ba_col", 32'({e.write, e.ba, e.col_ma}),
				32'({dec_o.write, dec_o.ba, dec_o.col_ma}));
		end
	endtask

	task automatic reg_scn();
		for (int i = 0; i < 5; i++)
			rd_chk("reset", 8'(4 * i), 32'h0000_0000);
		wr(8'h18, 32'hffff_ffff);
		rd_chk("unmapped", 8'h18, 32'h0000_0000);
	endtask

	task automatic init_scn();
		cmd_s q[$];
		int e[$];
		logic [2:0] ecmd[7] = '{CMD_PRE, CMD_MRS, CMD_MRS, CMD_PRE, CMD_REF,
			CMD_REF, CMD_MRS};
		int gap[7] = '{0, 1, 3, 3, 1 + TRP, 1 + TRFC, 1 + TRFC};
		wr(REG_CS0_BOUNDS, 32'h0080_0087);
		wr(REG_CS1_BOUNDS, 32'h0000_03ff);
		rd_chk("cs1_bounds", REG_CS1_BOUNDS, 32'h0000_03ff);
		wr(REG_CS0_GEOM, 32'h8000_0001);
		rd_chk("cs0_geom", REG_CS0_GEOM, 32'h8000_0001);
		repeat (40000) @(posedge sys_clk_i);
		u_ddr_mem_model.log_q.delete();
		u_ddr_mem_model.edge_q.delete();
		wr(REG_CTRL, 32'h8000_0000);
		@(posedge sys_clk_i);
		#1 chk("cke", 32'h1, 32'(mem_cke_o));
		chk("early_ready", 32'h0, 32'(req_ready_o));
		@(posedge sys_clk_i);
		req_valid_i <= 1'h1;
		@(posedge sys_clk_i);
		req_valid_i <= 1'h0;
		#1 chk("refused", 32'h0, 32'(dec_valid_o));
		wait_ready();
		q = u_ddr_mem_model.log_q;
		e = u_ddr_mem_model.edge_q;
		chk("cmd_count", 32'h7, 32'(q.size()));
		for (int i = 0; i < 7; i++) begin
			chk("cmd", 32'(ecmd[i]), 32'(q[i].rcw_n));
			chk("cs_n", 32'h2, 32'(q[i].cs_n));
			if (i > 0)
				chk("gap", 32'(gap[i]), 32'(e[i] - e[i - 1]));
		end
		chk("prea0", 32'h1, 32'(q[0].ma[MA_AP_BIT]));
		chk("prea3", 32'h1, 32'(q[3].ma[MA_AP_BIT]));
		chk("emrs", 32'h0000_4000, 32'({q[1].ba, q[1].ma}));
		chk("mrs_dll", 32'h0000_0121, 32'({q[2].ba, q[2].ma}));
		chk("mrs_run", 32'h0000_0021, 32'({q[6].ba, q[6].ma}));
		rd_chk("status", REG_STATUS, 32'h8000_0400);
	endtask

	task automatic narrow_scn();
		dec_chk(32'h21ff_fffe, 1'h1,
			exp_dec(32'h21ff_fffe, 12, 9, 1, 1'h0, 2'h1, 1'h1));
		dec_chk(32'h2000_0ace, 1'h0,
			exp_dec(32'h2000_0ace, 12, 9, 1, 1'h0, 2'h1, 1'h0));
		dec_chk(32'h2200_0000, 1'h0, '0);
		dec_chk(32'h0000_0100, 1'h0, '0);
	endtask

	task automatic wide_scn();
		wr(REG_CTRL, 32'h0000_0000);
		@(posedge sys_clk_i);
		#1 chk("cke_off", 32'h0, 32'(mem_cke_o));
		chk("deselect", 32'h3, 32'(mem_cmd_o.cs_n));
		wr(REG_CS0_GEOM, 32'h0000_0000);
		wr(REG_CS1_BOUNDS, 32'h0040_0041);
		wr(REG_CS1_GEOM, 32'h8080_0203);
		wr(REG_CTRL, 32'h8000_0001);
		wait_ready();
		dec_chk(32'h20ab_d5f4, 1'h1,
			exp_dec(32'h20ab_d5f4, 14, 11, 2, 1'h1, 2'h2, 1'h1));
		dec_chk(32'h2000_0000, 1'h0,
			exp_dec(32'h2000_0000, 14, 11, 2, 1'h1, 2'h2, 1'h0));
		dec_chk(32'h2100_0000, 1'h0, '0);
	endtask

	initial begin
		repeat (2) @(posedge sys_clk_i);
		resetn_i <= 1'h1;
		reg_scn();
		init_scn();
		narrow_scn();
		wide_scn();
		complete_run();
	end
endmodule
